// ---- hdl/rftd_consts.svh ----
`ifndef RFTD_CONSTS_SVH
`define RFTD_CONSTS_SVH

// Register offsets
`define RFTD_OFS_DRIVER_MODE 8'h28
`define RFTD_OFS_TRANSMIT_AMPLITUDE 8'h29
`define RFTD_OFS_TRANSMIT_CONTROL 8'h2A
`define RFTD_OFS_TRANSMIT_LOAD_OVERSHOOT 8'h2B

// Reset values
`define RFTD_RST_DRIVER_MODE 8'h00
`define RFTD_RST_TRANSMIT_AMPLITUDE 8'h00
`define RFTD_RST_TRANSMIT_CONTROL 8'h00
`define RFTD_RST_TRANSMIT_LOAD_OVERSHOOT 8'h00

// Writable bit masks, reserved bits stay zero
`define RFTD_MASK_DRIVER_MODE 8'hCF
`define RFTD_MASK_TRANSMIT_AMPLITUDE 8'hDF

// Driver mode fields
`define RFTD_BIT_SECOND_PIN_INVERT 7
`define RFTD_BIT_FIRST_PIN_INVERT 6
`define RFTD_BIT_DRIVER_PINS_ENABLE 3
`define RFTD_POS_DRIVE_STYLE 0

// Transmit amplitude fields
`define RFTD_POS_LEVEL_REDUCTION 6
`define RFTD_POS_RESIDUAL 0

// Transmit control fields
`define RFTD_POS_OVERSHOOT_EXTRA 4
`define RFTD_BIT_CARRIER_MAX 3
`define RFTD_BIT_MODULATION_INVERT 2
`define RFTD_POS_MODULATION_SOURCE 0

// Load and overshoot fields
`define RFTD_POS_OVERSHOOT_FIRST 4
`define RFTD_POS_LOAD_TRIM 0

// Carrier level reduction below the driver supply, in millivolts
`define RFTD_DROP_MV_0 10'h064
`define RFTD_DROP_MV_1 10'h0FA
`define RFTD_DROP_MV_2 10'h1F4
`define RFTD_DROP_MV_3 10'h3E8
`define RFTD_DROP_MV_NONE 10'h000

// Output drive style codes
`define RFTD_STYLE_HIGH_Z 3'h0
`define RFTD_STYLE_FIXED_LOW 3'h1
`define RFTD_STYLE_FIXED_HIGH 3'h2
`define RFTD_STYLE_BAD_A 3'h3
`define RFTD_STYLE_PUSH_PULL 3'h4
`define RFTD_STYLE_OPEN_DRAIN 3'h5
`define RFTD_STYLE_BAD_B 3'h6
`define RFTD_STYLE_PUSH_PULL_ALT 3'h7

// Modulation source codes
`define RFTD_SRC_NONE 2'h0
`define RFTD_SRC_ENVELOPE 2'h1
`define RFTD_SRC_EXTERNAL 2'h2
`define RFTD_SRC_RESERVED 2'h3

`endif

// ---- hdl/rftd_driver_pin.sv ----
`timescale 1ns/1ps
`include "rftd_consts.svh"
module rftd_driver_pin (
  // Clock and control
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Settings
  input wire logic pin_enable,
  input wire logic pin_invert,
  input wire logic [2:0] drive_style,
  // Carrier to drive
  input wire logic raw,
  // Pin drive
  output logic pin_out,
  output logic pin_oe
);

  logic out_q;
  logic out_d;
  logic oe_q;
  logic oe_d;
  logic level;

  // Pin level and enable from style, invert and enable
  always_comb
  begin
    level = raw ^ pin_invert;
    out_d = 1'b0;
    oe_d = 1'b0;
    if (pin_enable)
    begin
      case (drive_style)
        `RFTD_STYLE_FIXED_LOW:
        begin
          oe_d = 1'b1;
        end
        `RFTD_STYLE_FIXED_HIGH:
        begin
          out_d = 1'b1;
          oe_d = 1'b1;
        end
        `RFTD_STYLE_PUSH_PULL, `RFTD_STYLE_PUSH_PULL_ALT:
        begin
          out_d = level;
          oe_d = 1'b1;
        end
        `RFTD_STYLE_OPEN_DRAIN:
        begin
          oe_d = ~level; // Only pulls low
        end
        default:
        begin
          oe_d = 1'b0; // High impedance and unsupported codes
        end
      endcase
    end
    if (!clk_en)
    begin
      out_d = out_q;
      oe_d = oe_q;
    end
  end

  // Pin registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe = oe_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_pin_invert;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && pin_enable && drive_style == `RFTD_STYLE_PUSH_PULL) |=>
      (pin_out == ($past(raw) ^ $past(pin_invert)));
  endproperty
  a_pin_invert: assert property (p_pin_invert) else $error("pin invert wrong"); // [R01] [R02]

  property p_pin_off;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && !pin_enable) |=> !pin_oe;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("disabled pin still driven"); // [R03]

  property p_bad_style;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && (drive_style == `RFTD_STYLE_BAD_A || drive_style == `RFTD_STYLE_BAD_B))
      |=> !pin_oe;
  endproperty
  a_bad_style: assert property (p_bad_style) else $error("unsupported style drives pin"); // [R04]

  property p_fixed_high;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && pin_enable && drive_style == `RFTD_STYLE_FIXED_HIGH) |=> (pin_oe && pin_out);
  endproperty
  a_fixed_high: assert property (p_fixed_high) else $error("fixed high not driven"); // [R04]

endmodule

// ---- hdl/rftd_pkg.sv ----
package rftd_pkg;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rftd_req_t;

  // Settings handed to the analog driver stage
  typedef struct packed {
    logic [1:0] carrier_level_reduction;
    logic carrier_max;
    logic [9:0] drop_mv;
    logic [4:0] residual_carrier;
    logic [3:0] overshoot_first_value;
    logic [3:0] overshoot_extra_length;
    logic [3:0] load_current_trim;
  } rftd_analog_t;

  // Overshoot extension states
  typedef enum logic {RFTD_OVS_IDLE, RFTD_OVS_EXTEND} rftd_ovs_state_t;

endpackage

// ---- hdl/rftd_sync.sv ----
`timescale 1ns/1ps
module rftd_sync #(
  parameter int WIDTH = 2
) (
  // Clock and control
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Asynchronous inputs and their synchronised copies
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Next values of the two stages
  always_comb
  begin
    meta_d = clk_en ? async_in : meta_q;
    sync_d = clk_en ? meta_q : sync_q;
  end

  // Two flip-flop stages
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ---- hdl/rftd_top.sv ----
// Function
// R01: Bit 7 inverts second driver pin
// R02: Bit 6 inverts first driver pin
// R03: Bit 3 enables both driver pins
// R04: Style field picks drive; 011b, 110b unsupported
// R05: Maximum bit overrides carrier level reduction
// R06: Reduction codes mean 100/250/500/1000 mV
// R07: Residual carrier from amplitude bits 4..0
// R08: Extra overshoot modulation, carrier cycles, bits 7..4
// R09: Control bit 2 inverts chosen modulation
// R10: Source select: none, envelope, external, reserved
// R11: Load bits 7..4 give first overshoot value
// R12: Load bits 3..0 give load current trim
// R13: Reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "rftd_consts.svh"
module rftd_top (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire rftd_pkg::rftd_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Modulation and carrier inputs
  input wire logic internal_envelope,
  input wire logic external_signal_input,
  input wire logic carrier_in,
  // Driver pins
  output logic first_driver_pin_out,
  output logic first_driver_pin_oe,
  output logic second_driver_pin_out,
  output logic second_driver_pin_oe,
  // Analog stage settings and modulation
  output rftd_pkg::rftd_analog_t analog_cfg,
  output logic modulation_out
);
  import rftd_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [7:0] amp_q;
  logic [7:0] amp_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] load_q;
  logic [7:0] load_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Read mux shared by the read path
  function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] m,
                                          input logic [7:0] a, input logic [7:0] c,
                                          input logic [7:0] l);
    case (addr)
      `RFTD_OFS_DRIVER_MODE: reg_read = m;
      `RFTD_OFS_TRANSMIT_AMPLITUDE: reg_read = a;
      `RFTD_OFS_TRANSMIT_CONTROL: reg_read = c;
      `RFTD_OFS_TRANSMIT_LOAD_OVERSHOOT: reg_read = l;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Register writes and read data
  always_comb
  begin
    mode_d = mode_q;
    amp_d = amp_q;
    ctrl_d = ctrl_q;
    load_d = load_q;
    rdata_d = clk_en ? 8'h00 : rdata_q; // Frozen read data holds
    if (clk_en && reg_req.wr)
    begin
      case (reg_req.addr)
        `RFTD_OFS_DRIVER_MODE: mode_d = reg_req.wdata & `RFTD_MASK_DRIVER_MODE; // [R13]
        `RFTD_OFS_TRANSMIT_AMPLITUDE:
          amp_d = reg_req.wdata & `RFTD_MASK_TRANSMIT_AMPLITUDE; // [R13]
        `RFTD_OFS_TRANSMIT_CONTROL: ctrl_d = reg_req.wdata;
        `RFTD_OFS_TRANSMIT_LOAD_OVERSHOOT: load_d = reg_req.wdata;
        default: mode_d = mode_q;
      endcase
    end
    if (clk_en && reg_req.rd)
    begin
      rdata_d = reg_read(reg_req.addr, mode_q, amp_q, ctrl_q, load_q);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mode_q <= `RFTD_RST_DRIVER_MODE;
      amp_q <= `RFTD_RST_TRANSMIT_AMPLITUDE;
      ctrl_q <= `RFTD_RST_TRANSMIT_CONTROL;
      load_q <= `RFTD_RST_TRANSMIT_LOAD_OVERSHOOT;
      rdata_q <= 8'h00;
    end
    else
    begin
      mode_q <= mode_d;
      amp_q <= amp_d;
      ctrl_q <= ctrl_d;
      load_q <= load_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Field views
  wire logic second_pin_invert = mode_q[`RFTD_BIT_SECOND_PIN_INVERT];
  wire logic first_pin_invert = mode_q[`RFTD_BIT_FIRST_PIN_INVERT];
  wire logic driver_pins_enable = mode_q[`RFTD_BIT_DRIVER_PINS_ENABLE];
  wire logic [2:0] output_drive_style = mode_q[`RFTD_POS_DRIVE_STYLE +: 3];
  wire logic [1:0] carrier_level_reduction = amp_q[`RFTD_POS_LEVEL_REDUCTION +: 2];
  wire logic [4:0] residual_carrier = amp_q[`RFTD_POS_RESIDUAL +: 5];
  wire logic [3:0] overshoot_extra_length = ctrl_q[`RFTD_POS_OVERSHOOT_EXTRA +: 4];
  wire logic carrier_max = ctrl_q[`RFTD_BIT_CARRIER_MAX];
  wire logic modulation_invert = ctrl_q[`RFTD_BIT_MODULATION_INVERT];
  wire logic [1:0] modulation_source_select = ctrl_q[`RFTD_POS_MODULATION_SOURCE +: 2];
  wire logic [3:0] overshoot_first_value = load_q[`RFTD_POS_OVERSHOOT_FIRST +: 4];
  wire logic [3:0] load_current_trim = load_q[`RFTD_POS_LOAD_TRIM +: 4];

  // ----------------------------------------
  // Analog settings
  // ----------------------------------------
  rftd_analog_t cfg_q;
  rftd_analog_t cfg_d;

  // Offset below the driver supply for a reduction code
  function automatic logic [9:0] drop_of(input logic [1:0] code);
    case (code)
      2'h0: drop_of = `RFTD_DROP_MV_0;
      2'h1: drop_of = `RFTD_DROP_MV_1;
      2'h2: drop_of = `RFTD_DROP_MV_2;
      default: drop_of = `RFTD_DROP_MV_3;
    endcase
  endfunction

  // Settings image, maximum level cancels the reduction
  always_comb
  begin
    cfg_d = cfg_q;
    if (clk_en)
    begin
      cfg_d.carrier_level_reduction = carrier_level_reduction;
      cfg_d.carrier_max = carrier_max;
      cfg_d.drop_mv = carrier_max ? `RFTD_DROP_MV_NONE
        : drop_of(carrier_level_reduction); // [R05] [R06]
      cfg_d.residual_carrier = residual_carrier; // [R07]
      cfg_d.overshoot_first_value = overshoot_first_value; // [R11]
      cfg_d.overshoot_extra_length = overshoot_extra_length;
      cfg_d.load_current_trim = load_current_trim; // [R12]
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cfg_q <= '0;
    else
      cfg_q <= cfg_d;
  end

  assign analog_cfg = cfg_q;

  // ----------------------------------------
  // Modulation path
  // ----------------------------------------
  logic [1:0] pins_sync;

  rftd_sync #(.WIDTH(2)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in({external_signal_input, carrier_in}),
    .sync_out(pins_sync)
  );

  wire logic ext_sync = pins_sync[1];
  wire logic carrier_sync = pins_sync[0];

  logic mod_sel_q;
  logic mod_sel_d;
  logic carrier_prev_q;
  logic carrier_prev_d;
  logic [3:0] ovs_cnt_q;
  logic [3:0] ovs_cnt_d;
  rftd_ovs_state_t ovs_q;
  rftd_ovs_state_t ovs_d;
  logic mod_out_q;
  logic mod_out_d;
  logic carrier_rise;

  // Source choice, inversion and overshoot extension after a falling edge
  always_comb
  begin
    mod_sel_d = mod_sel_q;
    carrier_prev_d = carrier_prev_q;
    ovs_cnt_d = ovs_cnt_q;
    ovs_d = ovs_q;
    mod_out_d = mod_out_q;
    carrier_rise = carrier_sync & ~carrier_prev_q;
    if (clk_en)
    begin
      case (modulation_source_select) // [R10]
        `RFTD_SRC_ENVELOPE: mod_sel_d = internal_envelope ^ modulation_invert; // [R09]
        `RFTD_SRC_EXTERNAL: mod_sel_d = ext_sync ^ modulation_invert; // [R09]
        default: mod_sel_d = 1'b0;
      endcase
      carrier_prev_d = carrier_sync;
      case (ovs_q)
        RFTD_OVS_IDLE:
        begin
          if (mod_sel_q && !mod_sel_d && overshoot_extra_length != 4'h0)
          begin
            ovs_d = RFTD_OVS_EXTEND; // [R08]
            ovs_cnt_d = 4'h0;
          end
        end
        RFTD_OVS_EXTEND:
        begin
          if (mod_sel_d || ovs_cnt_q >= overshoot_extra_length)
            ovs_d = RFTD_OVS_IDLE;
          else if (carrier_rise)
            ovs_cnt_d = ovs_cnt_q + 4'h1; // [R08]
        end
        default: ovs_d = RFTD_OVS_IDLE;
      endcase
      mod_out_d = mod_sel_d | (ovs_d == RFTD_OVS_EXTEND);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mod_sel_q <= 1'b0;
      carrier_prev_q <= 1'b0;
      ovs_cnt_q <= 4'h0;
      ovs_q <= RFTD_OVS_IDLE;
      mod_out_q <= 1'b0;
    end
    else
    begin
      mod_sel_q <= mod_sel_d;
      carrier_prev_q <= carrier_prev_d;
      ovs_cnt_q <= ovs_cnt_d;
      ovs_q <= ovs_d;
      mod_out_q <= mod_out_d;
    end
  end

  assign modulation_out = mod_out_q;

  // ----------------------------------------
  // Driver pins
  // ----------------------------------------
  logic [1:0] pin_inv;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;

  assign pin_inv = {second_pin_invert, first_pin_invert}; // [R01] [R02]

  // One driver per pin, one enable for both
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin
      rftd_driver_pin u_pin (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .pin_enable(driver_pins_enable), // [R03]
        .pin_invert(pin_inv[gi]),
        .drive_style(output_drive_style), // [R04]
        .raw(carrier_sync),
        .pin_out(pin_out[gi]),
        .pin_oe(pin_oe[gi])
      );
    end
  endgenerate

  assign first_driver_pin_out = pin_out[0];
  assign first_driver_pin_oe = pin_oe[0];
  assign second_driver_pin_out = pin_out[1];
  assign second_driver_pin_oe = pin_oe[1];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  wire logic [4:0] wdata_res = reg_req.wdata[4:0];

  property p_cw_max;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && carrier_max) |=> (analog_cfg.drop_mv == `RFTD_DROP_MV_NONE);
  endproperty
  a_cw_max: assert property (p_cw_max) else $error("maximum level not applied"); // [R05]
  property p_drop_top;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && !carrier_max && carrier_level_reduction == 2'h3) |=>
      (analog_cfg.drop_mv == `RFTD_DROP_MV_3);
  endproperty
  a_drop_top: assert property (p_drop_top) else $error("reduction offset wrong"); // [R06]
  sequence s_amp_write;
    clk_en && reg_req.wr && reg_req.addr == `RFTD_OFS_TRANSMIT_AMPLITUDE ##1 clk_en;
  endsequence
  property p_residual;
    @(posedge sys_clk) disable iff (rst)
    s_amp_write |=> (analog_cfg.residual_carrier == $past(wdata_res, 2));
  endproperty
  a_residual: assert property (p_residual) else $error("residual carrier not taken"); // [R07]
  property p_overshoot;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && ovs_q == RFTD_OVS_IDLE && mod_sel_q && !mod_sel_d &&
      overshoot_extra_length != 4'h0)
      |=> (ovs_q == RFTD_OVS_EXTEND && modulation_out);
  endproperty
  a_overshoot: assert property (p_overshoot) else $error("overshoot extension missing"); // [R08]
  property p_envelope;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && modulation_source_select == `RFTD_SRC_ENVELOPE) |=>
      (mod_sel_q == ($past(internal_envelope) ^ $past(modulation_invert)));
  endproperty
  a_envelope: assert property (p_envelope) else $error("modulation source wrong"); // [R09] [R10]
  property p_reserved;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && reg_req.rd && reg_req.addr == `RFTD_OFS_DRIVER_MODE) |=> (reg_rdata[5:4] == 2'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [R13]

endmodule

// ---- tb/rftd_top_tb_top.sv ----
`timescale 1ns/1ps
module rftd_top_tb_top;
  import rftd_pkg::*;

`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic sys_clk;
  logic rst;
  logic clk_en;
  rftd_req_t reg_req;
  logic [7:0] reg_rdata;
  logic internal_envelope;
  logic external_signal_input;
  logic carrier_in;
  logic first_driver_pin_out;
  logic first_driver_pin_oe;
  logic second_driver_pin_out;
  logic second_driver_pin_oe;
  rftd_analog_t analog_cfg;
  logic modulation_out;
  int bad_count;
  int checks_done;
  logic [9:0] drop_tab [4];

  // Device under test
  rftd_top dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .internal_envelope(internal_envelope),
    .external_signal_input(external_signal_input),
    .carrier_in(carrier_in),
    .first_driver_pin_out(first_driver_pin_out),
    .first_driver_pin_oe(first_driver_pin_oe),
    .second_driver_pin_out(second_driver_pin_out),
    .second_driver_pin_oe(second_driver_pin_oe),
    .analog_cfg(analog_cfg),
    .modulation_out(modulation_out)
  );

  // Clock, 100 ns period
  always #50 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // One-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask

  // One-cycle read strobe, data sampled in the following cycle
  task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  // Let synchronisers and output flops settle
  task automatic settle;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  // Expected {oe, out} of one pin for a style and line level
  function automatic logic [1:0] pin_exp(input logic [2:0] s, input logic lvl);
    case (s)
      3'h1: return 2'b10;
      3'h2: return 2'b11;
      3'h4, 3'h7: return {1'b1, lvl};
      3'h5: return {~lvl, 1'b0};
      default: return 2'b00;
    endcase
  endfunction

  // Program driver mode, apply a carrier level, check both pins
  task automatic pin_case(input logic [7:0] mode, input logic c);
    logic [1:0] e1;
    logic [1:0] e2;
    reg_write(8'h28, mode);
    carrier_in <= c;
    settle();
    e1 = mode[3] ? pin_exp(mode[2:0], c ^ mode[6]) : 2'h0;
    e2 = mode[3] ? pin_exp(mode[2:0], c ^ mode[7]) : 2'h0;
    `CHK({first_driver_pin_oe, first_driver_pin_out}, e1)
    `CHK({second_driver_pin_oe, second_driver_pin_out}, e2)
  endtask

  // Print the counts and the verdict, then stop
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hung run
  initial
  begin
    repeat (50000) @(posedge sys_clk);
    bad_count++;
    $display("mismatch at %0t: run did not finish", $time);
    results();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    reg_req = '0;
    internal_envelope = 1'b0;
    external_signal_input = 1'b0;
    carrier_in = 1'b0;
    bad_count = 0;
    checks_done = 0;
    drop_tab = '{10'h064, 10'h0FA, 10'h1F4, 10'h3E8};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    // Reset state of outputs and registers
    `CHK(first_driver_pin_oe, 1'b0)
    `CHK(second_driver_pin_oe, 1'b0)
    for (int a = 8'h28; a <= 8'h2B; a++)
      check_reg(a[7:0], 8'h00);
    $display("test reset done");
    // Read back, reserved bits and unmapped places
    reg_write(8'h28, 8'hFF);
    check_reg(8'h28, 8'hCF);
    reg_write(8'h29, 8'hFF);
    check_reg(8'h29, 8'hDF);
    reg_write(8'h2A, 8'hFF);
    check_reg(8'h2A, 8'hFF);
    reg_write(8'h2B, 8'hFF);
    check_reg(8'h2B, 8'hFF);
    reg_write(8'h28, 8'h30);
    check_reg(8'h28, 8'h00);
    reg_write(8'h2C, 8'h5A);
    check_reg(8'h2C, 8'h00);
    check_reg(8'h27, 8'h00);
    $display("test registers done");
    // Amplitude reduction codes and residual carrier
    reg_write(8'h2A, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      reg_write(8'h29, {i[1:0], 1'b1, 5'h15});
      settle();
      `CHK(analog_cfg.carrier_level_reduction, i[1:0])
      `CHK(analog_cfg.drop_mv, drop_tab[i])
      `CHK(analog_cfg.residual_carrier, 5'h15)
    end
    // Maximum carrier overrides the reduction
    reg_write(8'h2A, 8'h58);
    settle();
    `CHK(analog_cfg.carrier_max, 1'b1)
    `CHK(analog_cfg.drop_mv, 10'h000)
    `CHK(analog_cfg.overshoot_extra_length, 4'h5)
    reg_write(8'h2B, 8'hA5);
    settle();
    `CHK(analog_cfg.overshoot_first_value, 4'hA)
    `CHK(analog_cfg.load_current_trim, 4'h5)
    reg_write(8'h2A, 8'h00);
    $display("test analog settings done");
    // Every drive style at both carrier levels
    for (int s = 0; s < 8; s++)
      for (int c = 0; c < 2; c++)
        pin_case({5'h01, s[2:0]}, c[0]);
    // Per-pin inversion under push-pull
    for (int v = 0; v < 4; v++)
      for (int c = 0; c < 2; c++)
        pin_case({v[1:0], 6'h0C}, c[0]);
    pin_case(8'hC4, 1'b1);
    $display("test driver pins done");
    // Modulation source and inversion, every code
    for (int k = 0; k < 32; k++)
    begin
      logic m_exp;
      reg_write(8'h2A, {5'h00, k[2:0]});
      internal_envelope <= k[3];
      external_signal_input <= k[4];
      settle();
      m_exp = (k[1:0] == 2'h1) ? k[3] ^ k[2] : (k[1:0] == 2'h2) ? k[4] ^ k[2] : 1'b0;
      `CHK(modulation_out, m_exp)
    end
    $display("test modulation done");
    // Overshoot extension of three carrier cycles
    reg_write(8'h2A, 8'h31);
    carrier_in <= 1'b0;
    internal_envelope <= 1'b1;
    settle();
    `CHK(modulation_out, 1'b1)
    @(posedge sys_clk);
    internal_envelope <= 1'b0;
    settle();
    `CHK(modulation_out, 1'b1)
    for (int p = 0; p < 3; p++)
    begin
      @(posedge sys_clk);
      carrier_in <= 1'b1;
      repeat (3) @(posedge sys_clk);
      carrier_in <= 1'b0;
      settle();
      `CHK(modulation_out, (p < 2) ? 1'b1 : 1'b0)
    end
    $display("test overshoot done");
    // Clock enable low freezes registers and settings
    reg_write(8'h2B, 8'h3C);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    reg_write(8'h2B, 8'hC3);
    settle();
    `CHK(analog_cfg.load_current_trim, 4'hC)
    `CHK(analog_cfg.overshoot_first_value, 4'h3)
    @(posedge sys_clk);
    clk_en <= 1'b1;
    check_reg(8'h2B, 8'h3C);
    $display("test clock enable done");
    results();
  end

endmodule
